// >>> core/led_sink_host.sv
`timescale 1ns/1ps
`default_nettype none
module led_sink_host
  import led_sink_pkg::*;
#(
  parameter int LAST = CHAIN_LAST_WIDE
)(
  input  wire logic            clk,
  input  wire logic            reset_n,
  led_link_if.host             link,
  input  wire logic            cmd_valid,
  input  wire logic [1:0]      cmd_op,
  input  wire logic [LAST:0]   cmd_pattern,
  output logic                 cmd_ready,
  output logic      [LAST:0]   read_data,
  output logic                 read_valid
);
  // cmd_op: 0 load+latch, 1 enter test, 2 detection pass+read, 3 exit
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SHIFT = 3'b001,
    H_PIN   = 3'b011,
    H_PULSE = 3'b010,
    H_DONE  = 3'b110
  } host_state_t;
  localparam int PULSE_W = 16;
  host_state_t state, next_state;
  logic [LAST:0]    sh, next_sh, rd, next_rd;
  logic [PULSE_W-1:0] cnt, next_cnt;
  logic [7:0]       bits, next_bits;
  logic [1:0]       op, next_op;
  logic [2:0]       step, next_step;
  logic             sclk, next_sclk, sin, next_sin, strobe, next_strobe, oe_n, next_oe_n;
  logic             rv, next_rv;

  // One serial clock pulse per bit; divider from the system clock
  always_comb begin
    next_state = state; next_sh = sh; next_rd = rd; next_cnt = cnt;
    next_bits = bits; next_op = op; next_step = step; next_sclk = sclk;
    next_sin = sin; next_strobe = strobe; next_oe_n = oe_n; next_rv = 1'b0;
    unique case (state)
      H_IDLE: begin
        if (cmd_valid) begin
          next_op = cmd_op; next_sh = cmd_pattern; next_step = 3'd0;
          next_bits = 8'(LAST + 1); next_cnt = '0;
          next_state = (cmd_op == 2'd0) ? H_SHIFT : H_PIN;
          if (cmd_op == 2'd0) next_oe_n = 1'b1;
        end
      end
      H_SHIFT: begin
        next_cnt = cnt + 1'b1;
        if (cnt == PULSE_W'(0)) begin
          next_sin = sh[LAST]; next_sclk = 1'b0;
        end else if (cnt == PULSE_W'(SCLK_HALF_CYCLES)) begin
          next_sclk = 1'b1;
          next_rd = {rd[LAST-1:0], link.serial_out};
        end else if (cnt == PULSE_W'(2*SCLK_HALF_CYCLES)) begin
          next_sclk = 1'b0; next_cnt = '0;
          next_sh = {sh[LAST-1:0], 1'b0}; next_bits = bits - 8'd1;
          if (bits == 8'd1) next_state = (op == 2'd0) ? H_PIN : H_DONE;
        end
      end
      H_PIN: begin
        // Steps set pins, then give pulses
        next_step = step + 3'd1; next_state = H_PULSE; next_cnt = '0;
        unique case (op)
          2'd0: begin
            next_strobe = (step == 3'd0);
            if (step == 3'd1) next_state = H_DONE;
          end
          2'd1: begin
            next_oe_n = 1'b1; next_strobe = (step == 3'd0);
            if (step == 3'd2) next_state = H_DONE;
          end
          2'd2: begin
            next_oe_n = (step != 3'd0);
            if (step == 3'd1) begin next_bits = 8'(LAST + 1); next_state = H_SHIFT; end
          end
          2'd3: begin
            // Strobe drops as the gate rises, so the counted pulses see it low
            next_strobe = (step == 3'd0); next_oe_n = (step != 3'd0);
            if (step == 3'd2) next_state = H_DONE;
          end
        endcase
      end
      H_PULSE: begin
        // Pulses in a phase; detection phase held long enough
        next_cnt = cnt + 1'b1;
        // Load phase keeps the clock still: a strobe held over a rise means entry
        next_sclk = (op != 2'd0) &&
                    ((cnt % PULSE_W'(2*SCLK_HALF_CYCLES)) >= PULSE_W'(SCLK_HALF_CYCLES));
        if (cnt >= PULSE_W'(((op == 2'd2) ? TEST_GATE_LOW_CYCLES : 0) + 4*SCLK_HALF_CYCLES*EXIT_PULSES)) begin
          next_sclk = 1'b0; next_state = H_PIN;
        end
      end
      H_DONE: begin
        next_rv = (op != 2'd1 && op != 2'd3); next_state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= H_IDLE; sh <= '0; rd <= '0; cnt <= '0; bits <= 8'd0; op <= 2'd0;
      step <= 3'd0; sclk <= 1'b0; sin <= 1'b0; strobe <= 1'b0; oe_n <= 1'b1; rv <= 1'b0;
      cmd_ready <= 1'b0; read_data <= '0; read_valid <= 1'b0;
    end else begin
      state <= next_state; sh <= next_sh; rd <= next_rd; cnt <= next_cnt;
      bits <= next_bits; op <= next_op; step <= next_step; sclk <= next_sclk;
      sin <= next_sin; strobe <= next_strobe; oe_n <= next_oe_n; rv <= next_rv;
      cmd_ready <= (next_state == H_IDLE);
      read_data <= next_rd; read_valid <= next_rv;
    end
  end

  assign link.serial_clk    = sclk;
  assign link.serial_in     = sin;
  assign link.latch_strobe  = strobe;
  assign link.output_gate_n = oe_n;
endmodule
`default_nettype wire

// >>> common/led_sink_pkg.sv
package led_sink_pkg;
  // Chain length n+1; n is 7 or 15
  localparam int CHAIN_LAST_NARROW = 7;
  localparam int CHAIN_LAST_WIDE   = 15;
  // Reset value of shift stages and latches
  localparam logic RESET_BIT = 1'b0;
  // Test pass timing
  localparam int CLK_PERIOD_NS        = 10;
  localparam int TEST_GATE_LOW_NS     = 2000;
  localparam int TEST_GATE_LOW_CYCLES = (TEST_GATE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TEST_PASS_PULSES     = 3;
  localparam int ENTRY_PULSES         = 1;
  localparam int EXIT_PULSES          = 3;
  // Host divider: serial clock half period in system cycles
  localparam int SCLK_HALF_CYCLES     = 2;
  // Mode sequencer states
  typedef enum logic [1:0] {
    MODE_NORMAL   = 2'b00,
    MODE_ENTRY    = 2'b01,
    MODE_TEST     = 2'b11,
    MODE_EXIT     = 2'b10
  } mode_t;
endpackage

// >>> common/led_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface led_link_if;
  logic serial_clk;
  logic serial_in;
  logic latch_strobe;
  logic output_gate_n;
  logic serial_out;
  modport device (
    input  serial_clk,
    input  serial_in,
    input  latch_strobe,
    input  output_gate_n,
    output serial_out
  );
  modport host (
    output serial_clk,
    output serial_in,
    output latch_strobe,
    output output_gate_n,
    input  serial_out
  );
endinterface
`default_nettype wire

// >>> core/mode_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module mode_sequencer
  import led_sink_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clk_rise,
  input  wire logic latch_strobe,
  input  wire logic output_gate_n,
  input  wire logic over_temperature_off,
  output logic      open_led_test,
  output logic      entry_block
);
  mode_t mode;
  mode_t next_mode;
  logic  prev_strobe;
  logic  prev_gate_n;
  logic  next_prev_strobe;
  logic  next_prev_gate_n;
  logic [1:0] pulses;
  logic [1:0] next_pulses;

  // Entry: strobe rises with gate high, then strobe low plus one edge.
  // Exit: gate pulses low while strobe high, then gate high plus three edges.
  always_comb begin
    next_mode        = mode;
    next_pulses      = pulses;
    next_prev_strobe = prev_strobe;
    next_prev_gate_n = prev_gate_n;
    if (clk_rise) begin
      next_prev_strobe = latch_strobe;
      next_prev_gate_n = output_gate_n;
      unique case (mode)
        MODE_NORMAL: begin
          // Steady pins are ordinary use; a strobe held over an edge starts entry
          if (latch_strobe && prev_strobe && output_gate_n && prev_gate_n) begin
            next_mode   = MODE_ENTRY;
            next_pulses = 2'd0;
          end
        end
        MODE_ENTRY: begin
          if (!latch_strobe) begin
            next_mode = MODE_TEST;
          end
        end
        MODE_TEST: begin
          if (latch_strobe && !output_gate_n) begin
            next_mode   = MODE_EXIT;
            next_pulses = 2'd0;
          end
        end
        MODE_EXIT: begin
          if (output_gate_n) begin
            next_pulses = pulses + 2'd1;
            if (pulses == 2'(EXIT_PULSES - 1)) begin
              next_mode = MODE_NORMAL;
            end
          end
        end
      endcase
    end
  end

  // Lockout-free power-on state is normal mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode        <= MODE_NORMAL;
      pulses      <= 2'd0;
      prev_strobe <= 1'b0;
      prev_gate_n <= 1'b1;
    end else begin
      mode        <= next_mode;
      pulses      <= next_pulses;
      prev_strobe <= next_prev_strobe;
      prev_gate_n <= next_prev_gate_n;
    end
  end

  assign open_led_test = (mode == MODE_TEST) || (mode == MODE_EXIT);
  // Strobe with clock must not copy data while the sequence is decoded
  // A rise with strobe and gate high is already part of the sequence
  assign entry_block   = (mode == MODE_ENTRY) ||
                         (mode == MODE_NORMAL && output_gate_n &&
                          (prev_strobe || (latch_strobe && clk_rise)));
endmodule
`default_nettype wire

// >>> core/led_sink_device.sv
`timescale 1ns/1ps
`default_nettype none
module led_sink_device
  import led_sink_pkg::*;
#(
  parameter int LAST = CHAIN_LAST_WIDE
)(
  input  wire logic            clk,
  input  wire logic            reset_n,
  led_link_if.device           link,
  input  wire logic [LAST:0]   above_threshold,
  input  wire logic            over_temperature_off,
  output logic      [LAST:0]   sink_on,
  output logic      [LAST:0]   latch_state,
  output logic                 open_led_test
);
  logic [LAST:0] chain;
  logic [LAST:0] next_chain;
  logic [LAST:0] latches;
  logic [LAST:0] next_latches;
  logic [LAST:0] next_sink_on;
  logic [LAST:0] error_bits;
  logic [LAST:0] next_error_bits;
  logic          serial_out;
  logic          prev_clk;
  logic          prev_gate_n;
  logic          clk_rise;
  logic          gate_rise;
  logic          test_mode;
  logic          entry_block;
  logic          next_open_led_test;

  mode_sequencer mode_sequencer_i (
    .clk                  (clk),
    .reset_n              (reset_n),
    .clk_rise             (clk_rise),
    .latch_strobe         (link.latch_strobe),
    .output_gate_n        (link.output_gate_n),
    .over_temperature_off (over_temperature_off),
    .open_led_test        (test_mode),
    .entry_block          (entry_block)
  );

  // Serial clock is a pin sampled on the system clock
  assign clk_rise  = link.serial_clk && !prev_clk;
  assign gate_rise = link.output_gate_n && !prev_gate_n;

  // Per-output error sampling while the gate is low in test mode
  genvar i;
  for (i = 0; i <= LAST; i++) begin : g_err
    always_comb begin
      next_error_bits[i] = error_bits[i];
      if (test_mode && !link.output_gate_n) begin
        next_error_bits[i] = latches[i] && above_threshold[i];
      end
    end
  end

  // Chain: shift on rising clock, error capture on gate rise
  always_comb begin
    next_chain = chain;
    if (test_mode && over_temperature_off) begin
      next_chain = '0;
    end else if (test_mode && gate_rise) begin
      next_chain = error_bits;
    end else if (clk_rise) begin
      next_chain = {chain[LAST-1:0], link.serial_in};
    end
  end

  // Transparent latches follow the chain while strobe is high, not during entry; in test mode only with gate high
  always_comb begin
    next_latches = latches;
    if (link.latch_strobe && !entry_block && !test_mode) begin
      next_latches = next_chain;
    end else if (link.latch_strobe && test_mode && !clk_rise && link.output_gate_n) begin
      next_latches = next_chain;
    end
  end

  // Gate only masks the drivers; latches untouched
  always_comb begin
    if (link.output_gate_n || over_temperature_off) begin
      next_sink_on = '0;
    end else begin
      next_sink_on = next_latches;
    end
    next_open_led_test = test_mode;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chain         <= '0;
      latches       <= '0;
      error_bits    <= '0;
      sink_on       <= '0;
      latch_state   <= '0;
      serial_out    <= 1'b0;
      prev_clk      <= 1'b0;
      prev_gate_n   <= 1'b1;
      open_led_test <= 1'b0;
    end else begin
      chain         <= next_chain;
      latches       <= next_latches;
      error_bits    <= next_error_bits;
      sink_on       <= next_sink_on;
      latch_state   <= next_latches;
      serial_out    <= next_chain[LAST];
      prev_clk      <= link.serial_clk;
      prev_gate_n   <= link.output_gate_n;
      open_led_test <= next_open_led_test;
    end
  end

  assign link.serial_out = serial_out;
endmodule
`default_nettype wire

// >>> bench/led_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module led_link_asserts
  import led_sink_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic latch_strobe,
  input wire logic output_gate_n,
  input wire logic serial_out,
  input wire logic over_temperature_off
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [9:0] low_cnt;
  logic [9:0] next_low_cnt;
  logic [3:0] rise_cnt;
  logic [3:0] next_rise_cnt;
  logic       sclk_d;
  logic       strobe_seen;
  logic       next_strobe_seen;

  // Gate-low span: cycles, clock rises, strobe activity (saturating)
  always_comb begin
    next_low_cnt = output_gate_n ? 10'h000 : low_cnt + {9'h000, low_cnt != 10'h3ff};
    next_rise_cnt = output_gate_n ? 4'h0
      : rise_cnt + {3'h0, serial_clk && !sclk_d && rise_cnt != 4'hf};
    next_strobe_seen = !output_gate_n && (strobe_seen || latch_strobe);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt  <= 10'h000;
      rise_cnt <= 4'h0;
      sclk_d   <= 1'b0;
      strobe_seen <= 1'b0;
    end else begin
      low_cnt  <= next_low_cnt;
      rise_cnt <= next_rise_cnt;
      sclk_d   <= serial_clk;
      strobe_seen <= next_strobe_seen;
    end
  end

  reset_idle_a: assert property ($rose(reset_n) |->
    output_gate_n && !serial_clk && !latch_strobe && !serial_out)
    else $error("link not idle after reset");
  sclk_high_a: assert property ($rose(serial_clk) |-> serial_clk[*2] ##1 !serial_clk)
    else $error("serial clock high width wrong");
  sclk_low_a: assert property ($fell(serial_clk) |-> !serial_clk[*2])
    else $error("serial clock low width short");
  data_stable_a: assert property (serial_clk |-> $stable(serial_in))
    else $error("serial data moved around clock rise");
  sout_hold_a: assert property (disable iff (!reset_n || over_temperature_off)
    (!serial_clk && output_gate_n)[*4] |=> $stable(serial_out))
    else $error("serial out changed without clock");
  strobe_short_a: assert property ($rose(latch_strobe) |-> ##[1:60] !latch_strobe)
    else $error("latch strobe left high");
  pass_time_a: assert property ($rose(output_gate_n) && rise_cnt != 4'h0 && !strobe_seen
    |-> low_cnt >= TEST_GATE_LOW_CYCLES)
    else $error("detection gate low too short");
  pass_pulses_a: assert property ($rose(output_gate_n) && rise_cnt != 4'h0 && !strobe_seen
    |-> rise_cnt >= TEST_PASS_PULSES)
    else $error("detection pass clock pulses too few");
endmodule
`default_nettype wire

// >>> bench/serial_led_sink_latch_open_detect_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_led_sink_latch_open_detect_tb
  import led_sink_pkg::*;
;
  localparam int LAST = CHAIN_LAST_NARROW;
  logic            clk = 1'b0;
  logic            reset_n = 1'b0;
  logic            cmd_valid = 1'b0;
  logic [1:0]      cmd_op = 2'h0;
  logic [LAST:0]   cmd_pattern = '0;
  logic [LAST:0]   above_threshold = '0;
  logic            over_temperature_off = 1'b0;
  logic            cmd_ready;
  logic [LAST:0]   read_data;
  logic            read_valid;
  logic [LAST:0]   sink_on;
  logic [LAST:0]   latch_state;
  logic            open_led_test;
  logic [LAST:0]   got;
  logic [LAST:0]   lit;
  int              bad_count = 0;
  int              compares = 0;
  logic [LAST:0]   pats [2] = '{8'ha5, 8'h3c};
  logic [LAST:0]   pass_pat [3] = '{8'hf0, 8'hf0, 8'h5a};
  logic [LAST:0]   pass_thr [3] = '{8'hcc, 8'hff, 8'h3c};

  always #5 clk = ~clk;

  led_link_if link_if ();

  led_sink_host #(.LAST(LAST)) led_sink_host_i (
    .clk         (clk),
    .reset_n     (reset_n),
    .link        (link_if.host),
    .cmd_valid   (cmd_valid),
    .cmd_op      (cmd_op),
    .cmd_pattern (cmd_pattern),
    .cmd_ready   (cmd_ready),
    .read_data   (read_data),
    .read_valid  (read_valid)
  );

  led_sink_device #(.LAST(LAST)) led_sink_device_i (
    .clk                  (clk),
    .reset_n              (reset_n),
    .link                 (link_if.device),
    .above_threshold      (above_threshold),
    .over_temperature_off (over_temperature_off),
    .sink_on              (sink_on),
    .latch_state          (latch_state),
    .open_led_test        (open_led_test)
  );

  led_link_asserts led_link_asserts_i (
    .clk                  (clk),
    .reset_n              (reset_n),
    .serial_clk           (link_if.serial_clk),
    .serial_in            (link_if.serial_in),
    .latch_strobe         (link_if.latch_strobe),
    .output_gate_n        (link_if.output_gate_n),
    .serial_out           (link_if.serial_out),
    .over_temperature_off (over_temperature_off)
  );

  task automatic check(input logic [LAST:0] seen, input logic [LAST:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // One host command; hold valid until taken, then wait for idle again
  task automatic run(input logic [1:0] op, input logic [LAST:0] pat, input logic [LAST:0] thr);
    int n;
    n = 0;
    got = 'x;
    lit = 'x;
    @(posedge clk);
    cmd_op          <= op;
    cmd_pattern     <= pat;
    above_threshold <= thr;
    cmd_valid       <= 1'b1;
    // Taken at the edge where ready is seen high
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
      if (read_valid === 1'b1) got = read_data;
      if (link_if.output_gate_n === 1'b0) lit = sink_on;
    end while ((cmd_ready !== 1'b1 || n < 2) && n < 5000);
    if (n >= 5000) bad_count++;
  endtask

  // Over-temperature burst: sinks dark, latches kept
  task automatic heat(input logic [LAST:0] held);
    @(posedge clk);
    over_temperature_off <= 1'b1;
    repeat (4) @(negedge clk);
    check(sink_on, 8'h00);
    check(latch_state, held);
    check({7'h00, link_if.serial_out}, 8'h00);
    @(posedge clk);
    over_temperature_off <= 1'b0;
  endtask

  task automatic test_done;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(negedge clk);
    check(latch_state, 8'h00);
    check({6'h00, open_led_test, link_if.output_gate_n}, 8'h01);
    // Back-to-back loads in normal mode
    foreach (pats[i]) begin
      run(2'h0, pats[i], 8'h00);
      check(latch_state, pats[i]);
      check(sink_on, link_if.output_gate_n ? 8'h00 : pats[i]);
      check({7'h00, link_if.serial_out}, {7'h00, pats[i][LAST]});
    end
    heat(pats[1]);
    run(2'h1, 8'h00, 8'h00);
    check({7'h00, open_led_test}, 8'h01);
    check(latch_state, pats[1]);
    // Repeated detection passes, pattern reloaded in test mode
    for (int i = 0; i < 3; i++) begin
      run(2'h0, pass_pat[i], pass_thr[i]);
      check(latch_state, pass_pat[i]);
      run(2'h2, 8'h00, pass_thr[i]);
      check(got, pass_pat[i] & pass_thr[i]);
      check(lit, pass_pat[i]);
    end
    heat(pass_pat[2]);
    run(2'h3, 8'h00, 8'h00);
    check({7'h00, open_led_test}, 8'h00);
    check(latch_state, pass_pat[2]);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
